// >>> ldi_ca_capture.sv
// module: double-rate command/address capture on the link clock edges
`timescale 1ns/1ps
`default_nettype none
module ldi_ca_capture
    import ldi_pkg::*;
(
    // clock and reset
    input  wire logic            mclk,
    input  wire logic            sys_rst,
    // link pins
    input  wire logic            linkClk,
    input  wire logic            cke,
    input  wire logic            csN,
    input  wire logic [CA_W-1:0] ca,
    // captured command
    output logic                 cmdValid,
    output logic [CA_W-1:0]      caRise,
    output logic [CA_W-1:0]      caFall,
    output logic                 ckeSync
);
    logic [1:0]      clkS_q;
    logic            clkPrev_q;
    logic [1:0]      ckeS_q;
    logic [1:0]      csS_q;
    logic [CA_W-1:0] caS1_q;
    logic [CA_W-1:0] caS2_q;
    logic            pend_q;

    // ------------------------------------------------------------
    // two-flop synchronisers; first stage read only by the second
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        clkS_q    <= {clkS_q[0], linkClk};
        ckeS_q    <= {ckeS_q[0], cke};
        csS_q     <= {csS_q[0], csN};
        caS1_q    <= ca;
        caS2_q    <= caS1_q;
        clkPrev_q <= clkS_q[1];
    end

    // ------------------------------------------------------------
    // one command per link cycle: rising half then falling half
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pend_q   <= 1'b0;
            cmdValid <= 1'b0;
            caRise   <= '0;
            caFall   <= '0;
            ckeSync  <= 1'b0;
        end
        else
        begin
            ckeSync  <= ckeS_q[1];
            cmdValid <= 1'b0;
            if (clkS_q[1] && !clkPrev_q)
            begin
                caRise <= caS2_q;
                pend_q <= ckeS_q[1] && !csS_q[1];
            end
            else if (!clkS_q[1] && clkPrev_q && pend_q)
            begin
                caFall   <= caS2_q;
                cmdValid <= 1'b1;
                pend_q   <= 1'b0;
            end
        end
    end
endmodule // ldi_ca_capture
`default_nettype wire

// >>> ldi_host_model.sv
// model: memory controller driving the command link
`timescale 1ns/1ps
`default_nettype none
module ldi_host_model
    import ldi_pkg::*;
(
    // clock
    input  wire logic       mclk,
    // link pins
    output logic            linkClk,
    output logic            cke,
    output logic            csN,
    output logic [CA_W-1:0] ca
);
    // --------------------
    // link clock and commands
    // --------------------
    localparam int INIT3_CYC = 200 * CLK_MHZ;
    initial
    begin
        linkClk = 1'b0;
        cke = 1'b0;
        csN = 1'b1;
        ca = 10'h155;
        #3.7;
        forever
            #62.5 linkClk = ~linkClk;
    end
    // pins move mid-phase, clear of the device's synchroniser delay
    task automatic phase(input bit rise);
        if (rise)
            @(posedge linkClk);
        else
            @(negedge linkClk);
        repeat (6) @(posedge mclk);
    endtask
    task automatic send(input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
        phase(1'b0);
        csN <= 1'b0;
        ca <= r;
        phase(1'b1);
        ca <= f;
        phase(1'b0);
        csN <= 1'b1; // spacing outlasts any burst
        ca <= ~f;
    endtask
    task automatic mrw(input logic [7:0] ma, input logic [7:0] op);
        send({ma[7:2], 4'h0}, {op, ma[1:0]});
    endtask
    task automatic mrr(input logic [7:0] ma);
        send({ma[7:2], 4'h8}, {8'h00, ma[1:0]});
    endtask
    task automatic setCke(input logic v);
        phase(1'b0);
        cke <= v;
    endtask
    task automatic powerup();
        repeat (8) @(posedge linkClk);
        // no termination pin is driven, so its level never moves
        setCke(1'b1);
        repeat (INIT3_CYC) @(posedge mclk);
    endtask
endmodule // ldi_host_model
`default_nettype wire

// >>> ldi_init_core.sv
// module: command decode, power-up init sequence and addressing core
`timescale 1ns/1ps
`default_nettype none
module ldi_init_core
    import ldi_pkg::*;
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // link pins
    input  wire logic              linkClk,
    input  wire logic              cke,
    input  wire logic              csN,
    input  wire logic [CA_W-1:0]   ca,
    // data pins, read side
    output logic [DQ_W-1:0]        dqOut,
    output logic                   dqOe,
    // core array port
    output logic                   coreRd,
    output logic                   coreWr,
    output logic [BANK_W-1:0]      coreBank,
    output logic [ROW_W-1:0]       coreRow,
    output logic [COL_W-1:0]       coreCol,
    // status
    output logic                   ready,
    output logic [NBANK-1:0]       bankOpen,
    output logic [6:0]             state
);
    logic              cmdValid;
    logic [CA_W-1:0]   caR;
    logic [CA_W-1:0]   caF;
    logic              ckeSync;
    ldi_state_t        st_q;
    logic [TMR_W-1:0]  tmr_q;
    logic              autoDone_q;
    logic [ROW_W-1:0]  openRow_q [NBANK];
    logic [2:0]        beat_q;
    logic              trainCa_q;

    ldi_ca_capture u_cap
    (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .linkClk  (linkClk),
        .cke      (cke),
        .csN      (csN),
        .ca       (ca),
        .cmdValid (cmdValid),
        .caRise   (caR),
        .caFall   (caF),
        .ckeSync  (ckeSync)
    );

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic ldi_cmd_t decode(input logic [CA_W-1:0] r);
        if (r[1:0] == 2'b00)
            decode = (r[3:2] == 2'b00) ? CMD_MRW :
                     (r[3:2] == 2'b10) ? CMD_MRR : CMD_REF;
        else if (r[1:0] == 2'b10)
            decode = CMD_ACT;
        else if (r[2:0] == 3'b101)
            decode = CMD_RD;
        else if (r[2:0] == 3'b001)
            decode = CMD_WR;
        else if (r[3:0] == 4'b1011)
            decode = CMD_PRE;
        else
            decode = CMD_NOP;
    endfunction

    function automatic logic [7:0] mrAddr(input logic [CA_W-1:0] r,
                                          input logic [CA_W-1:0] f);
        mrAddr = {r[9:4], f[1:0]};
    endfunction

    function automatic logic noRow(input logic [ROW_W-1:0] row);
        noRow = row[ROW_W-1] && row[ROW_W-2];
    endfunction

    ldi_cmd_t         cmd;
    logic [7:0]       ma;
    logic [7:0]       op;
    logic [ROW_W-1:0] actRow;
    logic [COL_W-1:0] rwCol;
    logic [BANK_W-1:0] bnk;
    always_comb
    begin
        cmd    = cmdValid ? decode(caR) : CMD_NOP;
        ma     = mrAddr(caR, caF);
        op     = caF[9:2];
        bnk    = caR[9:7];
        actRow = {caR[6:2], caF[9:0]};
        rwCol  = {caR[5:1] , caF[9:6], 1'b0};
    end

    // ------------------------------------------------------------
    // init state machine
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st_q       <= ST_OFF;
            tmr_q      <= '0;
            autoDone_q <= 1'b0;
            trainCa_q  <= 1'b0;
        end
        else
        begin
            if (tmr_q != '0)
                tmr_q <= tmr_q - 1'b1;
            if (cmd == CMD_MRW && ma == MA_RESET)
            begin
                // reset write restarts auto-init from any state
                st_q       <= ST_AUTO;
                autoDone_q <= 1'b0;
                tmr_q      <= TMR_W'(INIT5_CYC);
            end
            else
            begin
                case (st_q)
                    ST_OFF:
                        if (ckeSync)
                            st_q <= ST_WAIT;
                    ST_WAIT:
                        st_q <= ST_WAIT;
                    ST_AUTO:
                    begin
                        // internal work finishes well inside the maximum
                        if (tmr_q == TMR_W'(INIT5_CYC - AUTOINIT_CYC))
                            autoDone_q <= 1'b1;
                        if (autoDone_q || tmr_q == '0)
                            st_q <= ST_IDLE;
                    end
                    ST_IDLE:
                        if (cmd == CMD_MRW && (ma == MA_CATRN ||
                            ma == MA_CATRN2 ||
                            (ma == MA_FEAT2 && op[WRLEV_BIT])))
                        begin
                            st_q      <= ST_TRAIN;
                            trainCa_q <= (ma != MA_FEAT2);
                        end
                        else if (cmd == CMD_MRW && ma == MA_CAL)
                        begin
                            st_q  <= ST_ZQ;
                            tmr_q <= TMR_W'(ZQINIT_CYC);
                        end
                        else if ((cmd == CMD_RD || cmd == CMD_WR) &&
                                 bankOpen[bnk])
                        begin
                            st_q  <= ST_BURST;
                            tmr_q <= TMR_W'(BURST - 1);
                        end
                    ST_TRAIN:
                        if (cmd == CMD_MRW && ((trainCa_q &&
                            ma == MA_CAEXIT) || (!trainCa_q &&
                            ma == MA_FEAT2 && !op[WRLEV_BIT])))
                            st_q <= ST_IDLE;
                    ST_ZQ:
                        if (tmr_q == '0)
                            st_q <= ST_IDLE;
                    ST_BURST:
                        if (tmr_q == '0)
                            st_q <= ST_IDLE;
                    default:
                        st_q <= ST_OFF;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // bank tracking and core access
    // ------------------------------------------------------------
    logic inInit;
    always_comb
    begin
        inInit = (st_q == ST_OFF) || (st_q == ST_WAIT) ||
                 (st_q == ST_AUTO);
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            bankOpen <= '0;
            coreRd   <= 1'b0;
            coreWr   <= 1'b0;
            coreBank <= '0;
            coreRow  <= '0;
            coreCol  <= '0;
            for (int i = 0; i < NBANK; i++)
                openRow_q[i] <= '0;
        end
        else
        begin
            coreRd <= 1'b0;
            coreWr <= 1'b0;
            if (inInit || st_q == ST_TRAIN)
                bankOpen <= '0;
            else if (cmd == CMD_PRE)
                bankOpen <= caF[0] ? '0 : bankOpen & ~(NBANK'(1) << bnk);
            else if (cmd == CMD_ACT && !noRow(actRow))
            begin
                bankOpen[bnk]  <= 1'b1;
                openRow_q[bnk] <= actRow;
            end
            else if ((cmd == CMD_RD || cmd == CMD_WR) && bankOpen[bnk] &&
                     st_q == ST_IDLE)
            begin
                coreRd   <= (cmd == CMD_RD);
                coreWr   <= (cmd == CMD_WR) && !noRow(openRow_q[bnk]);
                coreBank <= bnk;
                coreRow  <= openRow_q[bnk];
                coreCol  <= rwCol;
            end
        end
    end

    // ------------------------------------------------------------
    // read-back of the status flag; buffer off while cke is low
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            dqOut <= '0;
            dqOe  <= 1'b0;
        end
        else if (!ckeSync)
        begin
            dqOe <= 1'b0;
        end
        else if (cmd == CMD_MRR && ma == MA_INFO)
        begin
            dqOut <= '0;
            dqOut[AUTOINIT_BIT] <= !(autoDone_q ||
                                     st_q != ST_AUTO);
            dqOe  <= 1'b1;
        end
        else
        begin
            dqOe <= 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ready <= 1'b0;
            state <= ST_OFF;
        end
        else
        begin
            ready <= (st_q == ST_IDLE);
            state <= st_q;
        end
    end
endmodule // ldi_init_core
`default_nettype wire

// >>> ldi_init_core_asserts.sv
// checker: timing and refusal properties at the init core ports
`timescale 1ns/1ps
`default_nettype none
module ldi_init_core_asserts
    import ldi_pkg::*;
(
    // clock and reset
    input wire logic              mclk,
    input wire logic              sys_rst,
    // pins and status
    input wire logic              cke,
    input wire logic              dqOe,
    input wire logic              coreRd,
    input wire logic              coreWr,
    input wire logic [BANK_W-1:0] coreBank,
    input wire logic [ROW_W-1:0]  coreRow,
    input wire logic [COL_W-1:0]  coreCol,
    input wire logic              ready,
    input wire logic [NBANK-1:0]  bankOpen,
    input wire logic [6:0]        state
);
    // --------------------
    // dwell counters
    // --------------------
    // counted, since a repetition cannot span hundreds of cycles cheaply
    logic [TMR_W-1:0] zqCnt_q;
    logic [TMR_W-1:0] autoCnt_q;
    always_ff @(posedge mclk)
        if (sys_rst || state != ST_ZQ)
            zqCnt_q <= '0;
        else
            zqCnt_q <= zqCnt_q + 1'b1;
    always_ff @(posedge mclk)
        if (sys_rst || state != ST_AUTO)
            autoCnt_q <= '0;
        else
            autoCnt_q <= autoCnt_q + 1'b1;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // --------------------
    // properties
    // --------------------
    hiz_cke_a:
        assert property (!cke && !$past(cke) |-> !dqOe)
        else $error("data driven with clock enable low");
    col_zero_a:
        assert property (coreRd || coreWr |-> !coreCol[0])
        else $error("lowest column bit set");
    core_pulse_a:
        assert property (coreRd || coreWr |=> !(coreRd || coreWr))
        else $error("core transfer longer than one clock");
    burst_len_a:
        assert property ($rose(state == ST_BURST) |->
            (state == ST_BURST) [*8] ##1 state != ST_BURST)
        else $error("burst busy time wrong");
    zq_min_a:
        assert property ($fell(state == ST_ZQ) |-> zqCnt_q >= ZQINIT_CYC)
        else $error("calibration ended early");
    auto_max_a:
        assert property (state == ST_AUTO |-> autoCnt_q < INIT5_CYC)
        else $error("auto init overran");
    hole_row_a:
        assert property (coreRd || coreWr |-> coreRow[14:13] != 2'h3)
        else $error("access to missing row");
    open_bank_a:
        assert property (coreRd || coreWr |-> bankOpen[coreBank])
        else $error("access to closed bank");
    train_stay_a:
        assert property (state == ST_TRAIN |=>
            state inside {ST_TRAIN, ST_IDLE, ST_AUTO})
        else $error("training left wrongly");
    zq_busy_a:
        assert property (state == ST_ZQ |-> !ready)
        else $error("ready during calibration");
    cover property ($rose(state == ST_ZQ));
    cover property ($rose(state == ST_TRAIN));
    cover property (coreWr);
endmodule // ldi_init_core_asserts

bind ldi_init_core ldi_init_core_asserts ldi_init_core_asserts_inst (
    .mclk(mclk), .sys_rst(sys_rst), .cke(cke), .dqOe(dqOe),
    .coreRd(coreRd), .coreWr(coreWr), .coreBank(coreBank),
    .coreRow(coreRow), .coreCol(coreCol), .ready(ready),
    .bankOpen(bankOpen), .state(state));
`default_nettype wire

// >>> ldi_init_core_test.sv
// testbench: power-up, calibration, training and access scenarios
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module ldi_init_core_test
    import ldi_pkg::*;
;
    logic              mclk = 1'b0;
    logic              sys_rst = 1'b1;
    wire logic         linkClk, cke, csN;
    wire logic [CA_W-1:0] ca;
    logic [DQ_W-1:0]   dqOut, lastDq;
    logic              dqOe, coreRd, coreWr, ready, accWr;
    logic [BANK_W-1:0] coreBank, accBank;
    logic [ROW_W-1:0]  coreRow, accRow;
    logic [COL_W-1:0]  coreCol, accCol;
    logic [NBANK-1:0]  bankOpen;
    logic [6:0]        state;
    int                n_mismatch = 0, checks = 0, nAcc = 0, nDq = 0;
    // --------------------
    // clock, parts and monitor
    // --------------------
    always #2.5 mclk = ~mclk;
    ldi_host_model ldi_host_model_inst (.mclk(mclk), .linkClk(linkClk),
        .cke(cke), .csN(csN), .ca(ca));
    ldi_init_core ldi_init_core_inst (.mclk(mclk), .sys_rst(sys_rst),
        .linkClk(linkClk), .cke(cke), .csN(csN), .ca(ca), .dqOut(dqOut),
        .dqOe(dqOe), .coreRd(coreRd), .coreWr(coreWr), .coreBank(coreBank),
        .coreRow(coreRow), .coreCol(coreCol), .ready(ready),
        .bankOpen(bankOpen), .state(state));
    always @(posedge mclk)
    begin
        if (dqOe === 1'b1)
        begin
            nDq++;
            lastDq = dqOut;
        end
        if (coreRd === 1'b1 || coreWr === 1'b1)
        begin
            nAcc++;
            accWr = coreWr;
            accBank = coreBank;
            accCol = coreCol;
            accRow = coreRow;
        end
    end
    // --------------------
    // scenarios
    // --------------------
    task automatic t_powerup();
        `CHK(dqOe, 1'b0)
        ldi_host_model_inst.powerup();
        ldi_host_model_inst.mrw(MA_RESET, 8'hFC);
        repeat (4) @(posedge mclk);
        `CHK(state, ST_AUTO)
        repeat (INIT4_CYC) @(posedge mclk);
        `CHK(state, ST_IDLE)
        `CHK(bankOpen, 8'h00)
        ldi_host_model_inst.mrr(MA_INFO);
        repeat (4) @(posedge mclk);
        `CHK(nDq, 1)
        `CHK(lastDq[AUTOINIT_BIT], 1'b0)
    endtask
    task automatic t_cal();
        ldi_host_model_inst.mrw(MA_CAL, 8'hFF);
        repeat (4) @(posedge mclk);
        `CHK(state, ST_ZQ)
        repeat (ZQINIT_CYC - 30) @(posedge mclk);
        `CHK(ready, 1'b0)
        for (int i = 0; i < 60 && ready !== 1'b1; i++)
            @(posedge mclk);
        `CHK(ready, 1'b1)
    endtask
    task automatic t_train();
        logic [7:0] enMa [3] = '{MA_CATRN, MA_CATRN2, MA_FEAT2};
        logic [7:0] exMa [3] = '{MA_CAEXIT, MA_CAEXIT, MA_FEAT2};
        logic [7:0] enOp [3] = '{8'h00, 8'h00, 8'h80};
        for (int k = 0; k < 3; k++)
        begin
            ldi_host_model_inst.mrw(enMa[k], enOp[k]);
            repeat (100) @(posedge mclk);
            `CHK(state, ST_TRAIN)
            ldi_host_model_inst.mrw(exMa[k], 8'h00);
            repeat (4) @(posedge mclk);
            `CHK(state, ST_IDLE)
        end
    endtask
    task automatic access(input logic [CA_W-1:0] r, input logic [CA_W-1:0] f,
                          input logic wr, input int nExp);
        int n0;
        n0 = nAcc;
        ldi_host_model_inst.send(r, f);
        repeat (4) @(posedge mclk);
        `CHK(nAcc, n0 + nExp)
        if (nExp > 0)
        begin
            `CHK(accWr, wr)
            `CHK(accBank, r[9:7])
            `CHK(accCol, {r[5:1], f[9:6], 1'b0})
        end
    endtask
    task automatic t_banks();
        ldi_host_model_inst.send(10'h292, 10'h234);
        ldi_host_model_inst.send(10'h162, 10'h000);
        repeat (4) @(posedge mclk);
        `CHK(bankOpen, 8'h20)
        access(10'h2B5, 10'h2C0, 1'b0, 1);
        `CHK(accRow, 15'h1234)
        access(10'h291, 10'h3C0, 1'b1, 1);
        access(10'h135, 10'h2C0, 1'b0, 0);
        // open bank 2, then close bank 5 alone
        ldi_host_model_inst.send(10'h102, 10'h000);
        ldi_host_model_inst.send(10'h28B, 10'h000);
        repeat (4) @(posedge mclk);
        `CHK(bankOpen, 8'h04)
        ldi_host_model_inst.send(10'h00B, 10'h001);
        ldi_host_model_inst.send(10'h00C, 10'h000);
        `CHK(bankOpen, 8'h00)
        `CHK(state, ST_IDLE)
        access(10'h2B5, 10'h2C0, 1'b0, 0);
    endtask
    task automatic t_ckeLow();
        ldi_host_model_inst.setCke(1'b0);
        ldi_host_model_inst.mrr(MA_INFO);
        repeat (4) @(posedge mclk);
        `CHK(nDq, 1)
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_powerup();
        t_cal();
        t_train();
        t_banks();
        t_ckeLow();
        tally_and_finish();
    end
    // power-up alone needs about 201 us
    initial
    begin
        #400000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule // ldi_init_core_test
`default_nettype wire

// >>> ldi_pkg.sv
// package: constants for the dram power-up, init and addressing block
package ldi_pkg;
    // ------------------------------------------------------------
    // bus and address widths
    // ------------------------------------------------------------
    localparam int CA_W    = 10;
    localparam int ROW_W   = 15;
    localparam int COL_W   = 10;
    localparam int BANK_W  = 3;
    localparam int NBANK   = 8;
    localparam int DQ_W    = 32;
    localparam int BURST   = 8;
    // ------------------------------------------------------------
    // timing, in the printed units, and derived cycle counts
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 200;
    localparam int INIT5_US     = 10;
    localparam int ZQINIT_US    = 1;
    localparam int INIT4_US     = 1;
    localparam int INIT5_CYC    = INIT5_US * CLK_MHZ;
    localparam int ZQINIT_CYC   = ZQINIT_US * CLK_MHZ;
    localparam int INIT4_CYC    = INIT4_US * CLK_MHZ;
    localparam int AUTOINIT_CYC = 64;
    localparam int TMR_W        = 16;
    // ------------------------------------------------------------
    // mode-register addresses and decoded commands
    // ------------------------------------------------------------
    localparam logic [7:0] MA_INFO   = 8'h00;
    localparam logic [7:0] MA_CAL    = 8'h0A;
    localparam logic [7:0] MA_CATRN  = 8'h29;
    localparam logic [7:0] MA_CATRN2 = 8'h30;
    localparam logic [7:0] MA_CAEXIT = 8'h2A;
    localparam logic [7:0] MA_RESET  = 8'h3F;
    localparam logic [7:0] MA_FEAT2  = 8'h02;
    localparam int         WRLEV_BIT = 7;
    localparam int         AUTOINIT_BIT = 0;

    typedef enum logic [3:0]
    {
        CMD_NOP = 4'h0,
        CMD_MRW = 4'h1,
        CMD_MRR = 4'h2,
        CMD_ACT = 4'h3,
        CMD_RD  = 4'h4,
        CMD_WR  = 4'h5,
        CMD_PRE = 4'h6,
        CMD_REF = 4'h7
    } ldi_cmd_t;

    typedef enum logic [6:0]
    {
        ST_OFF   = 7'h01,
        ST_WAIT  = 7'h02,
        ST_AUTO  = 7'h04,
        ST_IDLE  = 7'h08,
        ST_TRAIN = 7'h10,
        ST_ZQ    = 7'h20,
        ST_BURST = 7'h40
    } ldi_state_t;
endpackage : ldi_pkg
